// File: core/xu_pkg.sv
// package: opcodes, flag layout, cycle counts and register map of the execution unit
package xu_pkg;

	// instruction selector presented by the fetch stage
	typedef enum logic [5:0] {
		OP_ADD        = 6'h00,
		OP_ADC        = 6'h01,
		OP_ADD_WORD   = 6'h02,
		OP_SUB        = 6'h03,
		OP_SUB_IMM    = 6'h04,
		OP_SUB_BR_REG = 6'h05,
		OP_SUB_BR_IMM = 6'h06,
		OP_SUB_WORD   = 6'h07,
		OP_AND_REG    = 6'h08,
		OP_AND_IMM    = 6'h09,
		OP_OR_REG     = 6'h0A,
		OP_OR_IMM     = 6'h0B,
		OP_XOR_REG    = 6'h0C,
		OP_COM        = 6'h0D,
		OP_NEG        = 6'h0E,
		OP_SET_BITS   = 6'h0F,
		OP_CLR_BITS   = 6'h10,
		OP_ZM_TEST    = 6'h11,
		OP_MUL        = 6'h12,
		OP_MUL_S      = 6'h13,
		OP_MUL_SU     = 6'h14,
		OP_FRAC_MULT_UNSIGNED_U     = 6'h15,
		OP_FRAC_MULT_UNSIGNED_S     = 6'h16,
		OP_FRAC_MULT_UNSIGNED_SU    = 6'h17,
		OP_REL_JUMP   = 6'h18,
		OP_PTR_JUMP   = 6'h19,
		OP_ABS_JUMP   = 6'h1A,
		OP_REL_CALL   = 6'h1B,
		OP_PTR_CALL   = 6'h1C,
		OP_ABS_CALL   = 6'h1D,
		OP_RET        = 6'h1E,
		OP_IRQ_RET    = 6'h1F,
		OP_CMP_SKIP   = 6'h20,
		OP_CMP        = 6'h21,
		OP_CMP_BORROW = 6'h22,
		OP_CMP_IMM    = 6'h23,
		OP_SKIP_BIT0  = 6'h24
	} op_t;

	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_I = 7;

	// flags touched by each instruction group
	localparam logic [7:0] MASK_ARITH = 8'h2F;
	localparam logic [7:0] MASK_WORD  = 8'h1F;
	localparam logic [7:0] MASK_LOGIC = 8'h0E;
	localparam logic [7:0] MASK_COM   = 8'h0F;
	localparam logic [7:0] MASK_MULT  = 8'h03;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	// cycle counts per instruction group
	localparam logic [2:0] CYC_ONE   = 3'h1;
	localparam logic [2:0] CYC_TWO   = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR  = 3'h4;

	// register map, byte addresses
	localparam logic [7:0] ADDR_FLAGS  = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one instruction's effect, held until its last cycle
	typedef struct packed {
		logic        reg_wr;
		logic [7:0]  reg_data;
		logic        word_wr;
		logic        word_r1r0;
		logic [15:0] word_data;
		logic        pc_ld;
		logic [15:0] pc;
		logic        push;
		logic [15:0] push_pc;
		logic        pop;
		logic [7:0]  flags;
	} res_t;

endpackage : xu_pkg

// File: core/arith_branch_exec_unit.sv
// execution unit for arithmetic, logic and branch instructions with an AXI4-Lite flag port
`timescale 1ns/100ps
module arith_branch_exec_unit #(
	parameter bit HAS_DIRECT = 1'b1
) (
	input  logic          i_clock,
	input  logic          i_reset,
	input  logic          i_issue,
	input  xu_pkg::op_t   i_op,
	input  logic [7:0]    i_rd_value,
	input  logic [7:0]    i_rr_value,
	input  logic [7:0]    i_imm,
	input  logic [15:0]   i_word_value,
	input  logic [15:0]   i_z_pointer,
	input  logic [15:0]   i_pc,
	input  logic [11:0]   i_offset,
	input  logic [15:0]   i_target,
	input  logic [15:0]   i_stack_pc,
	input  logic          i_skip_long,
	output logic          o_busy,
	output logic          o_done,
	output logic          o_reg_write,
	output logic [7:0]    o_reg_data,
	output logic          o_word_write,
	output logic          o_word_r1r0,
	output logic [15:0]   o_word_data,
	output logic          o_pc_load,
	output logic [15:0]   o_pc_value,
	output logic          o_push,
	output logic [15:0]   o_push_value,
	output logic          o_pop,
	output logic [7:0]    o_flags,
	input  logic          i_awvalid,
	output logic          o_awready,
	input  logic [7:0]    i_awaddr,
	input  logic          i_wvalid,
	output logic          o_wready,
	input  logic [31:0]   i_wdata,
	input  logic [3:0]    i_wstrb,
	output logic          o_bvalid,
	input  logic          i_bready,
	output logic [1:0]    o_bresp,
	input  logic          i_arvalid,
	output logic          o_arready,
	input  logic [7:0]    i_araddr,
	output logic          o_rvalid,
	input  logic          i_rready,
	output logic [31:0]   o_rdata,
	output logic [1:0]    o_rresp
);

	xu_pkg::res_t  nx;
	xu_pkg::res_t  held;
	xu_pkg::res_t  out_q;
	xu_pkg::res_t  src;
	logic [2:0]    nx_cyc;
	logic [2:0]    cnt;
	logic [7:0]    sreg;
	logic [15:0]   last_pc;
	logic          issue_now;
	logic          emit;
	logic [7:0]    opa;
	logic [7:0]    opb;
	logic          cin;
	logic          sub;
	logic          chain_z;
	logic [8:0]    s9;
	logic [4:0]    h5;
	logic          v8;
	logic [16:0]   w17;
	logic [8:0]    ma;
	logic [8:0]    mb;
	logic [17:0]   prod;
	logic [15:0]   mres;
	logic [7:0]    lres;
	logic [7:0]    fv;
	logic          skip;
	logic          aw_got;
	logic          w_got;
	logic [7:0]    aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          commit;
	logic          flags_hit;

	assign issue_now = i_issue && !o_busy;
	assign src       = o_busy ? held : nx;
	assign emit      = (issue_now && nx_cyc == xu_pkg::CYC_ONE) || (o_busy && cnt == xu_pkg::CYC_ONE);

	// operand steering for the shared 8-bit adder
	always_comb begin
		opa     = i_rd_value;
		opb     = i_rr_value;
		cin     = 1'b0;
		sub     = 1'b0;
		chain_z = 1'b0;
		unique case (i_op)
			xu_pkg::OP_ADC: begin
				cin = sreg[xu_pkg::FLAG_C];
			end
			xu_pkg::OP_SUB, xu_pkg::OP_CMP: begin
				sub = 1'b1;
			end
			xu_pkg::OP_SUB_IMM, xu_pkg::OP_CMP_IMM: begin
				opb = i_imm;
				sub = 1'b1;
			end
			xu_pkg::OP_SUB_BR_REG, xu_pkg::OP_CMP_BORROW: begin
				sub     = 1'b1;
				cin     = sreg[xu_pkg::FLAG_C];
				chain_z = 1'b1;
			end
			xu_pkg::OP_SUB_BR_IMM: begin
				opb     = i_imm;
				sub     = 1'b1;
				cin     = sreg[xu_pkg::FLAG_C];
				chain_z = 1'b1;
			end
			xu_pkg::OP_NEG: begin
				opa = 8'h00;
				opb = i_rd_value;
				sub = 1'b1;
			end
			default: begin
				opb = i_rr_value;
			end
		endcase
	end

	// shared add and subtract with half carry
	assign s9 = sub ? ({1'b0, opa} - {1'b0, opb} - {8'h00, cin})
	                : ({1'b0, opa} + {1'b0, opb} + {8'h00, cin});
	assign h5 = sub ? ({1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin})
	                : ({1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin});
	assign v8 = sub ? ((opa[7] ^ opb[7]) & (s9[7] ^ opa[7]))
	                : (~(opa[7] ^ opb[7]) & (s9[7] ^ opa[7]));

	// word pair arithmetic, constant is six bits
	assign w17 = (i_op == xu_pkg::OP_SUB_WORD)
	           ? ({1'b0, i_word_value} - {11'h000, i_imm[5:0]})
	           : ({1'b0, i_word_value} + {11'h000, i_imm[5:0]});

	// operand extension picks signed or unsigned
	assign ma   = (i_op == xu_pkg::OP_MUL || i_op == xu_pkg::OP_FRAC_MULT_UNSIGNED_U)
	            ? {1'b0, i_rd_value} : {i_rd_value[7], i_rd_value};
	assign mb   = (i_op == xu_pkg::OP_MUL_S || i_op == xu_pkg::OP_FRAC_MULT_UNSIGNED_S)
	            ? {i_rr_value[7], i_rr_value} : {1'b0, i_rr_value};
	assign prod = 18'($signed(ma) * $signed(mb));
	assign mres = (i_op >= xu_pkg::OP_FRAC_MULT_UNSIGNED_U) ? {prod[14:0], 1'b0} : prod[15:0];

	always_comb begin
		unique case (i_op)
			xu_pkg::OP_AND_IMM: lres = i_rd_value & i_imm;
			xu_pkg::OP_CLR_BITS: lres = i_rd_value & (8'hFF - i_imm);
			xu_pkg::OP_OR_REG: lres = i_rd_value | i_rr_value;
			xu_pkg::OP_OR_IMM, xu_pkg::OP_SET_BITS: lres = i_rd_value | i_imm;
			xu_pkg::OP_XOR_REG: lres = i_rd_value ^ i_rr_value;
			xu_pkg::OP_COM: lres = 8'hFF - i_rd_value;
			default: lres = i_rd_value & (i_op == xu_pkg::OP_AND_REG ? i_rr_value : i_rd_value);
		endcase
	end

	assign skip = (i_op == xu_pkg::OP_CMP_SKIP) ? (i_rd_value == i_rr_value)
	            : !i_rr_value[i_imm[2:0]];

	// effect of the offered instruction
	always_comb begin
		nx       = '0;
		nx.flags = sreg;
		nx_cyc   = xu_pkg::CYC_ONE;
		fv       = 8'h00;
		unique case (i_op)
			xu_pkg::OP_ADD, xu_pkg::OP_ADC, xu_pkg::OP_SUB, xu_pkg::OP_SUB_IMM,
			xu_pkg::OP_SUB_BR_REG, xu_pkg::OP_SUB_BR_IMM, xu_pkg::OP_NEG,
			xu_pkg::OP_CMP, xu_pkg::OP_CMP_BORROW, xu_pkg::OP_CMP_IMM: begin
				nx.reg_data = s9[7:0];
				nx.reg_wr = !(i_op inside {xu_pkg::OP_CMP, xu_pkg::OP_CMP_BORROW,
				                           xu_pkg::OP_CMP_IMM});
				fv = {2'b00, h5[4], s9[7] ^ v8, v8, s9[7],
				      (s9[7:0] == 8'h00) && (!chain_z || sreg[xu_pkg::FLAG_Z]), s9[8]};
				nx.flags = (sreg & ~xu_pkg::MASK_ARITH) | (fv & xu_pkg::MASK_ARITH);
			end
			xu_pkg::OP_ADD_WORD, xu_pkg::OP_SUB_WORD: begin
				nx_cyc       = xu_pkg::CYC_TWO;
				nx.word_wr   = 1'b1;
				nx.word_data = w17[15:0];
				fv[xu_pkg::FLAG_Z] = (w17[15:0] == 16'h0000);
				fv[xu_pkg::FLAG_N] = w17[15];
				// overflow and carry of word add and subtract
				if (i_op == xu_pkg::OP_SUB_WORD) begin
					fv[xu_pkg::FLAG_V] = i_word_value[15] & ~w17[15];
					fv[xu_pkg::FLAG_C] = w17[15] & ~i_word_value[15];
				end else begin
					fv[xu_pkg::FLAG_V] = ~i_word_value[15] & w17[15];
					fv[xu_pkg::FLAG_C] = ~w17[15] & i_word_value[15];
				end
				fv[xu_pkg::FLAG_S] = fv[xu_pkg::FLAG_N] ^ fv[xu_pkg::FLAG_V];
				nx.flags = (sreg & ~xu_pkg::MASK_WORD) | (fv & xu_pkg::MASK_WORD);
			end
			xu_pkg::OP_AND_REG, xu_pkg::OP_AND_IMM, xu_pkg::OP_OR_REG, xu_pkg::OP_OR_IMM,
			xu_pkg::OP_XOR_REG, xu_pkg::OP_SET_BITS, xu_pkg::OP_CLR_BITS,
			xu_pkg::OP_ZM_TEST, xu_pkg::OP_COM: begin
				nx.reg_data = lres;
				// test leaves the register as it is
				nx.reg_wr = (i_op != xu_pkg::OP_ZM_TEST);
				fv[xu_pkg::FLAG_Z] = (lres == 8'h00);
				fv[xu_pkg::FLAG_N] = lres[7];
				fv[xu_pkg::FLAG_C] = 1'b1;
				// set bits shares the logic path
				nx.flags = (i_op == xu_pkg::OP_COM)
				         ? (sreg & ~xu_pkg::MASK_COM) | (fv & xu_pkg::MASK_COM)
				         : (sreg & ~xu_pkg::MASK_LOGIC) | (fv & xu_pkg::MASK_LOGIC);
			end
			xu_pkg::OP_MUL, xu_pkg::OP_MUL_S, xu_pkg::OP_MUL_SU,
			xu_pkg::OP_FRAC_MULT_UNSIGNED_U, xu_pkg::OP_FRAC_MULT_UNSIGNED_S, xu_pkg::OP_FRAC_MULT_UNSIGNED_SU: begin
				nx_cyc       = xu_pkg::CYC_TWO;
				nx.word_wr   = 1'b1;
				nx.word_r1r0 = 1'b1;
				nx.word_data = mres;
				fv[xu_pkg::FLAG_Z] = (mres == 16'h0000);
				fv[xu_pkg::FLAG_C] = prod[15];
				nx.flags = (sreg & ~xu_pkg::MASK_MULT) | (fv & xu_pkg::MASK_MULT);
			end
			// relative targets are PC plus k plus one
			xu_pkg::OP_REL_JUMP, xu_pkg::OP_REL_CALL: begin
				nx.pc_ld   = 1'b1;
				nx.pc      = i_pc + {{4{i_offset[11]}}, i_offset} + 16'h0001;
				nx.push    = (i_op == xu_pkg::OP_REL_CALL);
				nx.push_pc = i_pc + 16'h0001;
				nx_cyc     = nx.push ? xu_pkg::CYC_THREE : xu_pkg::CYC_TWO;
			end
			xu_pkg::OP_PTR_JUMP: begin
				nx.pc_ld = 1'b1;
				nx.pc    = i_z_pointer;
				nx_cyc   = xu_pkg::CYC_TWO;
			end
			xu_pkg::OP_PTR_CALL: begin
				nx.pc_ld   = 1'b1;
				nx.pc      = i_z_pointer;
				nx.push    = 1'b1;
				nx.push_pc = i_pc + 16'h0001;
				nx_cyc     = xu_pkg::CYC_THREE;
			end
			// absolute forms exist only on variants that have them
			xu_pkg::OP_ABS_JUMP, xu_pkg::OP_ABS_CALL: begin
				if (HAS_DIRECT) begin
					nx.pc_ld   = 1'b1;
					nx.pc      = i_target;
					nx.push    = (i_op == xu_pkg::OP_ABS_CALL);
					nx.push_pc = i_pc + 16'h0002;
					nx_cyc     = nx.push ? xu_pkg::CYC_FOUR : xu_pkg::CYC_THREE;
				end
			end
			xu_pkg::OP_RET, xu_pkg::OP_IRQ_RET: begin
				nx.pc_ld = 1'b1;
				nx.pc    = i_stack_pc;
				nx.pop   = 1'b1;
				nx_cyc   = xu_pkg::CYC_FOUR;
				if (i_op == xu_pkg::OP_IRQ_RET) begin
					nx.flags[xu_pkg::FLAG_I] = 1'b1;
				end
			end
			// bit-clear skip shares the skip path
			xu_pkg::OP_CMP_SKIP, xu_pkg::OP_SKIP_BIT0: begin
				// skip length follows skipped word count
				if (skip) begin
					nx.pc_ld = 1'b1;
					nx.pc    = i_pc + (i_skip_long ? 16'h0003 : 16'h0002);
					nx_cyc   = i_skip_long ? xu_pkg::CYC_THREE : xu_pkg::CYC_TWO;
				end
			end
			// unused codes retire as a one-cycle no-op
			default: begin
				nx_cyc = xu_pkg::CYC_ONE;
			end
		endcase
	end

	// multi-cycle sequencing; the issue is refused while busy
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_busy <= 1'b0;
			cnt    <= 3'h0;
			held   <= '0;
		end else if (issue_now && nx_cyc != xu_pkg::CYC_ONE) begin
			o_busy <= 1'b1;
			cnt    <= nx_cyc - 3'h1;
			held   <= nx;
		end else if (o_busy && cnt == xu_pkg::CYC_ONE) begin
			o_busy <= 1'b0;
		end else if (o_busy) begin
			cnt <= cnt - 3'h1;
		end
	end

	// results appear for one cycle on the last cycle
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			out_q  <= '0;
			o_done <= 1'b0;
		end else begin
			out_q  <= emit ? src : '0;
			o_done <= emit;
		end
	end

	// status flags: instruction update wins over a bus write in the same edge
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			sreg <= xu_pkg::FLAGS_RESET;
		end else if (emit) begin
			sreg <= src.flags;
		end else if (commit && flags_hit && i_wstrb[0]) begin
			sreg <= i_wdata[7:0];
		end
	end

	// last loaded program counter, for software inspection
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			last_pc <= 16'h0000;
		end else if (emit && src.pc_ld) begin
			last_pc <= src.pc;
		end
	end

	assign o_reg_write  = out_q.reg_wr;
	assign o_reg_data   = out_q.reg_data;
	assign o_word_write = out_q.word_wr;
	assign o_word_r1r0  = out_q.word_r1r0;
	assign o_word_data  = out_q.word_data;
	assign o_pc_load    = out_q.pc_ld;
	assign o_pc_value   = out_q.pc;
	assign o_push       = out_q.push;
	assign o_push_value = out_q.push_pc;
	assign o_pop        = out_q.pop;
	assign o_flags      = sreg;

	// write channel; address and data may arrive in either order
	assign commit    = aw_got && w_got && !o_bvalid;
	assign flags_hit = (aw_addr[7:2] == xu_pkg::ADDR_FLAGS[7:2]);
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			aw_got    <= 1'b0;
			w_got     <= 1'b0;
			aw_addr   <= 8'h00;
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_bvalid  <= 1'b0;
			o_bresp   <= xu_pkg::RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_got    <= 1'b1;
				aw_addr   <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_got    <= 1'b1;
				o_wready <= 1'b0;
			end
			if (commit) begin
				o_bvalid <= 1'b1;
				o_bresp  <= (flags_hit || aw_addr[7:2] == xu_pkg::ADDR_STATUS[7:2])
				          ? xu_pkg::RESP_OKAY : xu_pkg::RESP_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				aw_got    <= 1'b0;
				w_got     <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	// read channel; one read under way at a time
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h00000000;
			o_rresp   <= xu_pkg::RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rresp   <= xu_pkg::RESP_OKAY;
			if (i_araddr[7:2] == xu_pkg::ADDR_FLAGS[7:2]) begin
				o_rdata <= {24'h000000, sreg};
			end else if (i_araddr[7:2] == xu_pkg::ADDR_STATUS[7:2]) begin
				o_rdata <= {15'h0000, o_busy, last_pc};
			end else begin
				o_rdata <= 32'h00000000;
				o_rresp <= xu_pkg::RESP_SLVERR;
			end
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);

	a_add_one_cycle: assert property (issue_now && i_op == xu_pkg::OP_ADD |=>
		o_done && o_reg_write && o_reg_data == 8'($past(i_rd_value) + $past(i_rr_value)))
		else $error("add result or timing wrong");
	a_word_add_two: assert property (issue_now && i_op == xu_pkg::OP_ADD_WORD |=>
		!o_done ##1 o_done && o_word_write && !o_word_r1r0)
		else $error("word add not two cycles");
	a_word_sub_value: assert property (issue_now && i_op == xu_pkg::OP_SUB_WORD |->
		##2 o_word_data == $past(i_word_value, 2) - {10'h000, $past(i_imm[5:0], 2)})
		else $error("word subtract value wrong");
	a_borrow_sub_value: assert property (issue_now && i_op == xu_pkg::OP_SUB_BR_REG |=>
		o_reg_data == 8'($past(i_rd_value) - $past(i_rr_value)
		- {7'h00, $past(o_flags[xu_pkg::FLAG_C])}))
		else $error("borrow subtract value wrong");
	a_logic_flags: assert property (issue_now && i_op == xu_pkg::OP_XOR_REG |=>
		!o_flags[xu_pkg::FLAG_V] && $stable(o_flags[xu_pkg::FLAG_C]))
		else $error("logic op touched wrong flags");
	a_clear_bits_mask: assert property (issue_now && i_op == xu_pkg::OP_CLR_BITS |=>
		o_reg_data == ($past(i_rd_value) & ~$past(i_imm)))
		else $error("clear bits value wrong");
	a_test_zero_flag: assert property (issue_now && i_op == xu_pkg::OP_ZM_TEST |=>
		!o_reg_write && o_flags[xu_pkg::FLAG_Z] == ($past(i_rd_value) == 8'h00))
		else $error("test flags wrong");
	a_mult_to_pair: assert property (issue_now && i_op == xu_pkg::OP_MUL |->
		##2 o_word_r1r0 && o_word_data == 16'($past(i_rd_value, 2) * $past(i_rr_value, 2)))
		else $error("multiply product wrong");
	a_rel_call_three: assert property (issue_now && i_op == xu_pkg::OP_REL_CALL |=>
		!o_done [*2] ##1 o_done && o_pc_load && o_push)
		else $error("relative call timing wrong");
	a_ptr_jump_target: assert property (issue_now && i_op == xu_pkg::OP_PTR_JUMP |->
		##2 o_pc_load && o_pc_value == $past(i_z_pointer, 2))
		else $error("pointer jump target wrong");
	a_cmp_no_write: assert property (issue_now && i_op == xu_pkg::OP_CMP_IMM |=>
		o_done && !o_reg_write)
		else $error("compare wrote a register");
	a_skip_short: assert property (issue_now && i_op == xu_pkg::OP_CMP_SKIP
		&& i_rd_value == i_rr_value && !i_skip_long |-> ##2 o_pc_load
		&& o_pc_value == $past(i_pc, 2) + 16'h0002)
		else $error("short skip wrong");
	a_return_pop: assert property (issue_now && i_op == xu_pkg::OP_IRQ_RET |->
		##4 o_done && o_pop && o_flags[xu_pkg::FLAG_I])
		else $error("interrupt return wrong");

endmodule : arith_branch_exec_unit

// File: dv/core_stack_model.sv
// partner model: the core's return stack, filled by calls and emptied by returns
`timescale 1ns/100ps
module core_stack_model (
	input  logic        i_clock,
	input  logic        i_reset,
	input  logic        i_push,
	input  logic [15:0] i_push_value,
	input  logic        i_pop,
	output logic [15:0] o_top
);
	logic [15:0] slot [0:7];
	logic [2:0]  depth;
	logic [15:0] noise;

	// an empty stack shows a moving pattern, so a stray return never sees a stale address
	assign o_top = (depth == 3'h0) ? noise : slot[depth - 3'h1];

	// push on a call's retirement, pop on a return's; depth wraps past eight entries
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			depth <= 3'h0;
			noise <= 16'hA5C3;
		end else begin
			noise <= ~{noise[14:0], noise[15]};
			if (i_push) begin
				slot[depth] <= i_push_value;
				depth       <= depth + 3'h1;
			end else if (i_pop) begin
				depth <= depth - 3'h1;
			end
		end
	end
endmodule : core_stack_model

// File: dv/arith_branch_exec_unit_bench.sv
// testbench: instruction rows, flag register port, busy and reset cases
`timescale 1ns/100ps
module arith_branch_exec_unit_bench;
	typedef struct packed {
		logic [5:0]  op;
		logic [7:0]  rd;
		logic [7:0]  rr;
		logic [7:0]  imm;
		logic [7:0]  fl;
		logic [15:0] w;
		logic [15:0] p;
		logic [2:0]  k;
		logic [2:0]  n;
		logic [15:0] ev;
		logic [7:0]  ef;
	} row_t;
	logic        i_clock, i_reset, i_issue, i_skip_long, i_bready, i_rready;
	xu_pkg::op_t i_op;
	logic [7:0]  i_rd_value, i_rr_value, i_imm, i_awaddr, i_araddr, o_reg_data, o_flags;
	logic [15:0] i_word_value, i_z_pointer, i_pc, i_target, i_stack_pc;
	logic [15:0] o_word_data, o_pc_value, o_push_value;
	logic [11:0] i_offset;
	logic        o_busy, o_done, o_reg_write, o_word_write, o_word_r1r0, o_pc_load, o_push, o_pop;
	logic        i_awvalid, i_wvalid, i_arvalid, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [31:0] i_wdata, o_rdata, rd_data;
	logic [3:0]  i_wstrb;
	logic [1:0]  o_bresp, o_rresp, resp;
	logic [16:0] got;
	logic [2:0]  wexp [0:4];
	row_t        rows [$];
	int          fail_count, compares, n;

	arith_branch_exec_unit arith_branch_exec_unit_inst (.*);
	core_stack_model core_stack_model_inst (.i_clock(i_clock), .i_reset(i_reset), .i_push(o_push),
		.i_push_value(o_push_value), .i_pop(o_pop), .o_top(i_stack_pc));

	// 125 MHz core clock
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t %s got %h expected %h", $time, what, g, e);
		end
	endtask : chk

	// write address and data offered together, each released once taken
	task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		int t;
		t = 0;
		i_awaddr  <= a;
		i_wdata   <= {24'h000000, d};
		i_wstrb   <= s;
		i_awvalid <= 1'b1;
		i_wvalid  <= 1'b1;
		i_bready  <= 1'b1;
		do begin
			@(posedge i_clock);
			t++;
			if (o_awready === 1'b1) i_awvalid <= 1'b0;
			if (o_wready === 1'b1) i_wvalid <= 1'b0;
		end while (o_bvalid !== 1'b1 && t < 40);
		// bready stays high, so back-to-back writes never lower and raise it in one step
		if (t >= 40) fail_count++;
		resp = o_bresp;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		int t;
		t = 0;
		i_araddr  <= a;
		i_arvalid <= 1'b1;
		i_rready  <= 1'b1;
		do begin
			@(posedge i_clock);
			t++;
			if (o_arready === 1'b1) i_arvalid <= 1'b0;
		end while (o_rvalid !== 1'b1 && t < 40);
		if (t >= 40) fail_count++;
		rd_data = o_rdata;
		resp = o_rresp;
	endtask : axi_read

	// offer one instruction and count cycles up to its retirement
	task automatic issue(input row_t r);
		i_op         <= xu_pkg::op_t'(r.op);
		i_rd_value   <= r.rd;
		i_rr_value   <= r.rr;
		i_imm        <= r.imm;
		i_offset     <= {{4{r.imm[7]}}, r.imm};
		i_skip_long  <= r.imm[6];
		i_word_value <= r.w;
		i_z_pointer  <= r.w;
		i_target     <= r.w;
		i_pc         <= r.p;
		i_issue      <= 1'b1;
		@(posedge i_clock);
		i_issue <= 1'b0;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_done !== 1'b1 && n < 9);
	endtask : issue

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		fail_count = 0;
		compares = 0;
		{i_issue, i_skip_long, i_bready, i_rready, i_awvalid, i_wvalid, i_arvalid} = 7'h00;
		{i_rd_value, i_rr_value, i_imm, i_awaddr, i_araddr} = 40'h0;
		{i_word_value, i_z_pointer, i_pc, i_target, i_offset, i_wstrb} = 80'h0;
		i_wdata = 32'h0;
		i_op = xu_pkg::OP_ADD;
		i_reset = 1'b1;
		// value kinds: reg, pair, product, pc, none -> {reg_write, word_write, pc_load}
		wexp = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h0};
		rows = '{
	'{6'h00,8'h0F,8'h01,8'h00,8'h00,16'h0000,16'h0000,3'h0,3'h1,16'h0010,8'h20},
	'{6'h03,8'h20,8'h01,8'h00,8'h00,16'h0000,16'h0000,3'h0,3'h1,16'h001F,8'h20},
	'{6'h09,8'hF0,8'h00,8'h0F,8'h08,16'h0000,16'h0000,3'h0,3'h1,16'h0000,8'h02},
	'{6'h0D,8'h0F,8'h00,8'h00,8'h00,16'h0000,16'h0000,3'h0,3'h1,16'h00F0,8'h05},
	'{6'h0E,8'h01,8'h00,8'h00,8'h00,16'h0000,16'h0000,3'h0,3'h1,16'h00FF,8'h25},
	'{6'h21,8'h05,8'h05,8'h00,8'h00,16'h0000,16'h0000,3'h4,3'h1,16'h0000,8'h02},
	'{6'h22,8'h05,8'h04,8'h00,8'h01,16'h0000,16'h0000,3'h4,3'h1,16'h0000,8'h00},
	'{6'h01,8'h7F,8'h00,8'h00,8'h01,16'h0000,16'h0000,3'h0,3'h1,16'h0080,8'h2C},
	'{6'h02,8'h00,8'h00,8'h01,8'h00,16'hFFFF,16'h0000,3'h1,3'h2,16'h0000,8'h03},
	'{6'h07,8'h00,8'h00,8'h01,8'h00,16'h0000,16'h0000,3'h1,3'h2,16'hFFFF,8'h15},
	'{6'h05,8'h10,8'h01,8'h00,8'h03,16'h0000,16'h0000,3'h0,3'h1,16'h000E,8'h20},
	'{6'h04,8'h05,8'h00,8'h05,8'h00,16'h0000,16'h0000,3'h0,3'h1,16'h0000,8'h02},
	'{6'h06,8'h00,8'h00,8'h00,8'h01,16'h0000,16'h0000,3'h0,3'h1,16'h00FF,8'h25},
	'{6'h08,8'hF0,8'h3C,8'h00,8'h09,16'h0000,16'h0000,3'h0,3'h1,16'h0030,8'h01},
	'{6'h0A,8'h01,8'h02,8'h00,8'h04,16'h0000,16'h0000,3'h0,3'h1,16'h0003,8'h00},
	'{6'h0B,8'h80,8'h00,8'h01,8'h00,16'h0000,16'h0000,3'h0,3'h1,16'h0081,8'h04},
	'{6'h0C,8'h5A,8'h5A,8'h00,8'h20,16'h0000,16'h0000,3'h0,3'h1,16'h0000,8'h22},
	'{6'h10,8'hFF,8'h00,8'h0F,8'h00,16'h0000,16'h0000,3'h0,3'h1,16'h00F0,8'h04},
	'{6'h0F,8'h00,8'h00,8'h00,8'h00,16'h0000,16'h0000,3'h0,3'h1,16'h0000,8'h02},
	'{6'h11,8'h80,8'h00,8'h00,8'h00,16'h0000,16'h0000,3'h4,3'h1,16'h0000,8'h04},
	'{6'h12,8'hFF,8'hFF,8'h00,8'h00,16'h0000,16'h0000,3'h2,3'h2,16'hFE01,8'h01},
	'{6'h13,8'hFF,8'h01,8'h00,8'h00,16'h0000,16'h0000,3'h2,3'h2,16'hFFFF,8'h01},
	'{6'h14,8'hFF,8'h02,8'h00,8'h00,16'h0000,16'h0000,3'h2,3'h2,16'hFFFE,8'h01},
	'{6'h15,8'h80,8'h80,8'h00,8'h01,16'h0000,16'h0000,3'h2,3'h2,16'h8000,8'h00},
	'{6'h16,8'h80,8'h80,8'h00,8'h01,16'h0000,16'h0000,3'h2,3'h2,16'h8000,8'h00},
	'{6'h17,8'h80,8'h02,8'h00,8'h00,16'h0000,16'h0000,3'h2,3'h2,16'hFE00,8'h01},
	'{6'h18,8'h00,8'h00,8'hFF,8'h3F,16'h0000,16'h0100,3'h3,3'h2,16'h0100,8'h3F},
	'{6'h19,8'h00,8'h00,8'h00,8'h00,16'h1234,16'h0100,3'h3,3'h2,16'h1234,8'h00},
	'{6'h1A,8'h00,8'h00,8'h00,8'h00,16'h2345,16'h0100,3'h3,3'h3,16'h2345,8'h00},
	'{6'h1B,8'h00,8'h00,8'h05,8'h00,16'h0000,16'h0010,3'h3,3'h3,16'h0016,8'h00},
	'{6'h1C,8'h00,8'h00,8'h00,8'h00,16'h0200,16'h0020,3'h3,3'h3,16'h0200,8'h00},
	'{6'h1D,8'h00,8'h00,8'h00,8'h00,16'h4000,16'h0030,3'h3,3'h4,16'h4000,8'h00},
	'{6'h1E,8'h00,8'h00,8'h00,8'h00,16'h0000,16'h0000,3'h3,3'h4,16'h0032,8'h00},
	'{6'h1F,8'h00,8'h00,8'h00,8'h00,16'h0000,16'h0000,3'h3,3'h4,16'h0021,8'h80},
	'{6'h20,8'h33,8'h33,8'h00,8'h21,16'h0000,16'h0040,3'h3,3'h2,16'h0042,8'h21},
	'{6'h20,8'h33,8'h33,8'h40,8'h21,16'h0000,16'h0040,3'h3,3'h3,16'h0043,8'h21},
	'{6'h20,8'h33,8'h34,8'h00,8'h21,16'h0000,16'h0040,3'h4,3'h1,16'h0000,8'h21},
	'{6'h23,8'h10,8'h00,8'h20,8'h00,16'h0000,16'h0000,3'h4,3'h1,16'h0000,8'h05},
	'{6'h24,8'h00,8'hF7,8'h43,8'h00,16'h0000,16'h0050,3'h3,3'h3,16'h0053,8'h00},
	'{6'h24,8'h00,8'h01,8'h00,8'h00,16'h0000,16'h0050,3'h4,3'h1,16'h0000,8'h00}};
		repeat (4) @(posedge i_clock);
		i_reset <= 1'b0;
		chk(32'({o_busy, o_flags, o_awready, o_wready, o_arready, o_bvalid}), 32'hE, "reset");
		// every row: cycles, flags, strobes; value for every kind but none
		foreach (rows[j]) begin
			axi_write(8'h00, rows[j].fl, 4'h1);
			issue(rows[j]);
			got = (rows[j].k == 3'h0) ? {9'h000, o_reg_data} :
				(rows[j].k == 3'h3) ? {1'b0, o_pc_value} : {o_word_r1r0, o_word_data};
			chk(32'(n), 32'(rows[j].n), "cycles");
			chk(32'(o_flags), 32'(rows[j].ef), "flags");
			chk(32'({o_reg_write, o_word_write, o_pc_load}), 32'(wexp[rows[j].k]), "strobes");
			// calls push their return address, returns pop it
			chk(32'({o_push, o_pop}),
				32'({rows[j].op inside {6'h1B, 6'h1C, 6'h1D}, rows[j].op inside {6'h1E, 6'h1F}}),
				"stack");
			if (rows[j].k != 3'h4) chk(32'(got), 32'({rows[j].k == 3'h2, rows[j].ev}), "value");
		end
		// flag register: strobe honoured, status read, unmapped refused
		axi_write(8'h00, 8'h5A, 4'h1);
		axi_write(8'h00, 8'hFF, 4'h0);
		axi_read(8'h00);
		chk(rd_data, 32'h5A, "flags readback");
		axi_write(8'h04, 8'hFF, 4'h1);
		chk(32'(resp), 32'(xu_pkg::RESP_OKAY), "status write");
		axi_read(8'h04);
		chk(rd_data, 32'h53, "status");
		axi_read(8'h08);
		chk({rd_data[29:0], resp}, 32'(xu_pkg::RESP_SLVERR), "unmapped read");
		axi_write(8'h0C, 8'h00, 4'h1);
		chk(32'(resp), 32'(xu_pkg::RESP_SLVERR), "unmapped write");
		i_op <= xu_pkg::OP_MUL;
		i_issue <= 1'b1;
		@(posedge i_clock);
		i_op <= xu_pkg::OP_ADD;
		@(posedge i_clock);
		chk(32'(o_busy), 32'h1, "busy while multiplying");
		i_issue <= 1'b0;
		n = 0;
		repeat (5) begin
			@(posedge i_clock);
			n += int'(o_done === 1'b1);
		end
		chk(32'(n), 32'h1, "retire while busy");
		// return cut by reset never retires
		i_op <= xu_pkg::OP_RET;
		i_issue <= 1'b1;
		@(posedge i_clock);
		i_issue <= 1'b0;
		@(posedge i_clock);
		i_reset <= 1'b1;
		@(posedge i_clock);
		chk(32'({o_busy, o_flags}), 32'h0, "reset mid run");
		i_reset <= 1'b0;
		n = 0;
		repeat (6) begin
			@(posedge i_clock);
			n += int'(o_done === 1'b1);
		end
		chk(32'(n), 32'h0, "aborted return");
		report_and_stop();
	end
endmodule : arith_branch_exec_unit_bench
